/* common/diidp_pkg.sv */
// Purpose: shared constants and carrier types of the dual I/Q
//          interpolating converter data path
// Assumes: one 25 MHz clock; all inputs synchronous to it
// Notes:   codes are straight binary, 10 bits wide
package diidp_pkg;

    // clock and pin timing
    localparam int CLK_HZ = 25_000_000;
    localparam int CLK_PERIOD_NS = 40;
    localparam int MAX_CLK_MHZ = 40;

    // widths and depths
    localparam int CODE_W = 10;
    localparam int PAIR_W = 2 * CODE_W;
    localparam int FIFO_DEPTH = 32;
    localparam int SEG_N = 15;
    localparam int LOW_W = 2;

    // code field positions for the segment decoder
    localparam int UPPER_MSB = 9;
    localparam int UPPER_LSB = 6;
    localparam int MID_MSB = 5;
    localparam int MID_LSB = 2;
    localparam int LOW_MSB = 1;

    // reset / sleep input: cycles held before power-down
    localparam int SLEEP_CNT_W = 3;
    localparam logic [SLEEP_CNT_W-1:0] SLEEP_CYCLES = 3'h4;

    // half-band interpolator
    localparam int TAPS = 43;
    localparam int HALF_TAPS = 11;
    localparam int DL_LEN = 2 * HALF_TAPS;
    localparam int CENTRE_IDX = HALF_TAPS;
    localparam int COEF_W = 12;
    localparam int ACC_W = 28;
    localparam int COEF_SHIFT = 10;
    localparam logic signed [ACC_W-1:0] ACC_ROUND = 28'sh0000200;
    localparam logic signed [ACC_W-1:0] ACC_MAX = 28'sh00001FF;
    localparam logic signed [ACC_W-1:0] ACC_MIN = 28'shFFFFE00;

    // non-zero taps of the odd phase, innermost first; they sum to
    // half of the 1 << COEF_SHIFT gain on each side of the centre
    localparam logic signed [COEF_W-1:0] HB_COEF [HALF_TAPS] = '{
        12'h283, 12'hF37, 12'h070, 12'hFB9, 12'h02F, 12'hFE1,
        12'h014, 12'hFF4, 12'h007, 12'hFFC, 12'h002
    };

    // reset values
    localparam logic [CODE_W-1:0] CODE_ZERO = 10'h000;
    localparam logic [CODE_W-1:0] CODE_MID = 10'h200;

    typedef enum logic [1:0] {
        PAIR_WAIT_I = 2'b00,
        PAIR_WAIT_Q = 2'b01
    } diidp_pair_state_t;

    typedef struct packed {
        logic [CODE_W-1:0] i;
        logic [CODE_W-1:0] q;
    } diidp_pair_t;

    typedef struct packed {
        logic [SEG_N-1:0] upper;
        logic [SEG_N-1:0] middle;
        logic [LOW_W-1:0] low;
    } diidp_seg_t;

endpackage

/* rtl/diidp_fifo.sv */
// Purpose: sample-pair buffer between the input interface and filters
// Assumes: single clock; clear drops every stored word
// Notes:   storage in flip-flops, read by index
`timescale 1ns/1ps
`default_nettype none
module diidp_fifo #(
    parameter int WIDTH = 20,
    parameter int DEPTH = 32
) (
    // clock and reset
    input wire logic clock,
    input wire logic rstn,
    input wire logic clear,
    // fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW:0] wr_ptr;
        logic [AW:0] rd_ptr;
    } diidp_fifo_st_t;

    diidp_fifo_st_t st_q;
    diidp_fifo_st_t st_d;
    logic full;
    logic empty;
    logic push;
    logic pop;

    assign full = (st_q.wr_ptr[AW] != st_q.rd_ptr[AW]) &&
                  (st_q.wr_ptr[AW-1:0] == st_q.rd_ptr[AW-1:0]);
    assign empty = st_q.wr_ptr == st_q.rd_ptr;
    assign in_ready = !full && !clear;
    assign out_valid = !empty && !clear;
    assign out_data = st_q.mem[st_q.rd_ptr[AW-1:0]];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always_comb begin
        st_d = st_q;
        if (clear) begin
            st_d.wr_ptr = '0;
            st_d.rd_ptr = '0;
        end else begin
            if (push) begin
                st_d.mem[st_q.wr_ptr[AW-1:0]] = in_data;
                st_d.wr_ptr = st_q.wr_ptr + 1'b1;
            end
            if (pop) begin
                st_d.rd_ptr = st_q.rd_ptr + 1'b1;
            end
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

endmodule
`default_nettype wire

/* rtl/diidp_core.sv */
// Purpose: interleaved I/Q input interface, two 2x half-band
//          interpolators and segment decoders of a dual converter
// Assumes: inputs synchronous to clock; host keeps clock <= 40 MHz
// Notes:   segment outputs steer current switches of the analog array
// Notes on behaviour
// - both channels load together every clock edge
// - I and Q alternate on one 10-bit bus
// - interpolation doubles rate, one sample per clock
// - identical 43-tap symmetric half-band filters per channel
// - each filter sees only its own channel
// - filter clock is input clock divided by two
// - two filter paths, taken on alternate phases
// - de-interleave and keep each I with its Q
// - reset/sleep clears pairing and powers down
// - top four bits drive fifteen equal segments
// - middle four bits sixteenth segments, rest binary
// - straight binary; zero code, no true current
// - four or more cycles held enters power-down
// - select high steers to I, low to Q
// - channel registers capture on write rising edge
`timescale 1ns/1ps
`default_nettype none
module diidp_core
    import diidp_pkg::*;
(
    // clock and reset
    input wire logic clock,
    input wire logic rstn,
    // host input bus
    input wire logic [CODE_W-1:0] input_code_bits,
    input wire logic write_strobe,
    input wire logic channel_select,
    input wire logic reset_sleep,
    output logic pair_ready,
    // converter switch drive
    output diidp_seg_t i_segments,
    output diidp_seg_t q_segments,
    output logic power_down
);

    typedef struct packed {
        diidp_pair_state_t pair;
        logic wr_prev;
        logic [CODE_W-1:0] i_hold;
        logic [SLEEP_CNT_W-1:0] sleep_cnt;
        logic sleep;
        logic fen;
        logic [DL_LEN-1:0][CODE_W-1:0] dl_i;
        logic [DL_LEN-1:0][CODE_W-1:0] dl_q;
        logic [CODE_W-1:0] pa_i;
        logic [CODE_W-1:0] pb_i;
        logic [CODE_W-1:0] pa_q;
        logic [CODE_W-1:0] pb_q;
        logic [CODE_W-1:0] dac_i;
        logic [CODE_W-1:0] dac_q;
        diidp_seg_t seg_i;
        diidp_seg_t seg_q;
    } diidp_core_st_t;

    // offset binary to two's complement, sign-extended by one bit
    function automatic logic signed [CODE_W:0] to_signed(
        input logic [CODE_W-1:0] c
    );
        return {~c[CODE_W-1], ~c[CODE_W-1], c[CODE_W-2:0]};
    endfunction

    // odd phase of the half-band: symmetric pairs times the taps
    function automatic logic [CODE_W-1:0] hb_mac(
        input logic [DL_LEN-1:0][CODE_W-1:0] dl
    );
        logic signed [ACC_W-1:0] acc;
        logic signed [CODE_W+1:0] s;
        acc = '0;
        s = '0;
        for (int m = 0; m < HALF_TAPS; m++) begin
            s = (CODE_W+2)'(to_signed(dl[CENTRE_IDX-1-m])) +
                (CODE_W+2)'(to_signed(dl[CENTRE_IDX+m]));
            acc = acc + ACC_W'(s * HB_COEF[m]);
        end
        acc = (acc + ACC_ROUND) >>> COEF_SHIFT;
        if (acc > ACC_MAX) begin
            acc = ACC_MAX;
        end else if (acc < ACC_MIN) begin
            acc = ACC_MIN;
        end
        return {~acc[CODE_W-1], acc[CODE_W-2:0]};
    endfunction

    // four bits to fifteen equal thermometer switches
    function automatic logic [SEG_N-1:0] therm4(input logic [3:0] v);
        logic [SEG_N-1:0] t;
        t = '0;
        for (int k = 0; k < SEG_N; k++) begin
            t[k] = v > 4'(k);
        end
        return t;
    endfunction

    function automatic diidp_seg_t seg_decode(
        input logic [CODE_W-1:0] c
    );
        diidp_seg_t s;
        s.upper = therm4(c[UPPER_MSB:UPPER_LSB]);
        s.middle = therm4(c[MID_MSB:MID_LSB]);
        s.low = c[LOW_MSB:0];
        return s;
    endfunction

    diidp_core_st_t st_q;
    diidp_core_st_t st_d;
    logic wr_rise;
    logic push;
    diidp_pair_t push_pair;
    logic pop_valid;
    logic pop_ready;
    diidp_pair_t pop_pair;
    logic [CODE_W-1:0] next_i;
    logic [CODE_W-1:0] next_q;

    assign wr_rise = write_strobe && !st_q.wr_prev;
    assign pop_ready = st_q.fen && !st_q.sleep;

    diidp_fifo #(
        .WIDTH(PAIR_W),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clock(clock),
        .rstn(rstn),
        .clear(st_q.sleep),
        .in_valid(push),
        .in_ready(pair_ready),
        .in_data(push_pair),
        .out_valid(pop_valid),
        .out_ready(pop_ready),
        .out_data(pop_pair)
    );

    always_comb begin
        st_d = st_q;
        push = 1'b0;
        push_pair = '{i: st_q.i_hold, q: input_code_bits};
        next_i = CODE_ZERO;
        next_q = CODE_ZERO;
        st_d.wr_prev = write_strobe;

        // held-length counter splits reset from power-down
        if (reset_sleep) begin
            if (st_q.sleep_cnt != SLEEP_CYCLES) begin
                st_d.sleep_cnt = st_q.sleep_cnt + 1'b1;
            end
        end else begin
            st_d.sleep_cnt = '0;
        end
        st_d.sleep = reset_sleep && (st_d.sleep_cnt == SLEEP_CYCLES);

        // pairing state machine; a Q without an I is dropped
        if (reset_sleep) begin
            st_d.pair = PAIR_WAIT_I;
        end else if (wr_rise) begin
            unique case (st_q.pair)
                PAIR_WAIT_I: begin
                    if (channel_select) begin
                        st_d.i_hold = input_code_bits;
                        st_d.pair = PAIR_WAIT_Q;
                    end
                end
                PAIR_WAIT_Q: begin
                    if (channel_select) begin
                        st_d.i_hold = input_code_bits;
                    end else begin
                        push = 1'b1;
                        st_d.pair = PAIR_WAIT_I;
                    end
                end
                default: st_d.pair = PAIR_WAIT_I;
            endcase
        end

        // filter clock as an enable every second input clock
        st_d.fen = !st_q.fen;

        // one input pair per filter clock; each line its own channel
        if (st_q.fen && pop_valid && !st_q.sleep) begin
            st_d.dl_i = {st_q.dl_i[DL_LEN-2:0], pop_pair.i};
            st_d.dl_q = {st_q.dl_q[DL_LEN-2:0], pop_pair.q};
        end

        // both paths computed at the filter rate, same taps for I and Q
        if (st_q.fen) begin
            st_d.pa_i = st_q.dl_i[CENTRE_IDX];
            st_d.pa_q = st_q.dl_q[CENTRE_IDX];
            st_d.pb_i = hb_mac(st_q.dl_i);
            st_d.pb_q = hb_mac(st_q.dl_q);
        end

        // alternate paths on opposite filter phases
        if (st_q.fen) begin
            next_i = st_q.pb_i;
            next_q = st_q.pb_q;
        end else begin
            next_i = st_q.pa_i;
            next_q = st_q.pa_q;
        end

        // both converters latched on the same edge; zero code from the
        // edge that raises power-down, so no switch is left on in sleep
        if (st_d.sleep) begin
            st_d.dac_i = CODE_ZERO;
            st_d.dac_q = CODE_ZERO;
        end else begin
            st_d.dac_i = next_i;
            st_d.dac_q = next_q;
        end
        st_d.seg_i = seg_decode(st_d.dac_i);
        st_d.seg_q = seg_decode(st_d.dac_q);
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign i_segments = st_q.seg_i;
    assign q_segments = st_q.seg_q;
    assign power_down = st_q.sleep;

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rstn);

    a_sleep_entry: assert property (
        reset_sleep [*4] |=> power_down
    ) else $error("power-down not entered after four held cycles");

    a_short_reset: assert property (
        !reset_sleep ##1 reset_sleep [*3] ##1 !reset_sleep |-> !power_down
    ) else $error("short reset pulse entered power-down");

    a_pair_reset: assert property (
        reset_sleep |=> st_q.pair == PAIR_WAIT_I && !push
    ) else $error("pairing not reset by reset input");

    a_i_capture: assert property (
        (wr_rise && channel_select && !reset_sleep) |=>
            st_q.i_hold == $past(input_code_bits)
    ) else $error("I word not captured on write edge");

    a_pair_push: assert property (
        push |-> st_q.pair == PAIR_WAIT_Q && !channel_select && wr_rise
    ) else $error("pair pushed out of order");

    a_filter_div: assert property (
        st_q.fen |=> !st_q.fen ##1 st_q.fen
    ) else $error("filter enable is not half rate");

    a_pop_rate: assert property (
        (pop_valid && st_q.fen && !st_q.sleep) |=>
            (st_q.dl_i[0] == $past(pop_pair.i) &&
             st_q.dl_q[0] == $past(pop_pair.q)) ##1
            (st_q.dl_i[0] == $past(pop_pair.i, 2))
    ) else $error("input pair not taken on filter clock");

    a_centre_pass: assert property (
        (st_q.fen && !st_q.sleep && !reset_sleep) ##1 !st_q.sleep |=>
            st_q.dac_i == $past(st_q.dl_i[CENTRE_IDX], 2) &&
            st_q.dac_q == $past(st_q.dl_q[CENTRE_IDX], 2)
    ) else $error("centre tap does not pass samples through");

    a_seg_zero: assert property (
        (st_q.dac_i == CODE_ZERO) == (i_segments == '0)
    ) else $error("zero code does not clear all switches");

    a_sleep_quiet: assert property (
        power_down |-> i_segments == '0 && q_segments == '0
    ) else $error("switches active in power-down");

endmodule
`default_nettype wire

/* testbench/diidp_host_model.sv */
// Purpose: host model driving interleaved I/Q words and reset/sleep
// Assumes: one clock; the host changes its pins 1 ns after a rising edge
// Notes:   the bus shows the inverted word while the strobe is low
`timescale 1ns/1ps
`default_nettype none
module diidp_host_model
    import diidp_pkg::*;
(
    // clock and flow control
    input wire logic clock,
    input wire logic pair_ready,
    // host bus
    output logic [CODE_W-1:0] input_code_bits,
    output logic write_strobe,
    output logic channel_select,
    output logic reset_sleep
);
    initial begin
        input_code_bits = CODE_ZERO;
        write_strobe = 1'b0;
        channel_select = 1'b0;
        reset_sleep = 1'b0;
    end

    // one word takes two clocks: strobe high, then low
    task automatic put_word(input logic [CODE_W-1:0] w, input logic sel);
        @(posedge clock);
        #1;
        input_code_bits = w;
        channel_select = sel;
        write_strobe = 1'b1;
        @(posedge clock);
        #1;
        write_strobe = 1'b0;
        input_code_bits = ~w;
    endtask

    // I first, then its Q, once pair_ready is seen or after 64 clocks of waiting
    task automatic send_pair(input logic [CODE_W-1:0] i,
                             input logic [CODE_W-1:0] q, output logic ok);
        int n;
        for (n = 0; n < 64 && pair_ready !== 1'b1; n++) begin
            @(posedge clock);
            #1;
        end
        ok = (pair_ready === 1'b1);
        put_word(i, 1'b1);
        put_word(q, 1'b0);
    endtask

    // reset/sleep held high for a given number of sampled cycles
    task automatic hold_sleep(input int cycles);
        @(posedge clock);
        #1;
        reset_sleep = 1'b1;
        repeat (cycles) @(posedge clock);
        #1;
        reset_sleep = 1'b0;
    endtask
endmodule
`default_nettype wire

/* testbench/diidp_core_tb_top.sv */
// Purpose: self-checking bench of the dual I/Q converter data path
// Assumes: 25 MHz clock; inputs move 1 ns after the rising edge
// Notes:   the pair buffer is exercised through the converter path
`timescale 1ns/1ps
`default_nettype none
module diidp_core_tb_top
    import diidp_pkg::*;
();
    logic clock;
    logic rstn;
    logic [CODE_W-1:0] input_code_bits;
    logic write_strobe;
    logic channel_select;
    logic reset_sleep;
    logic pair_ready;
    diidp_seg_t i_segments;
    diidp_seg_t q_segments;
    logic power_down;
    int err_total = 0;
    int num_checks = 0;
    int cycles = 0;

    diidp_core diidp_core_inst (.clock(clock), .rstn(rstn),
        .input_code_bits(input_code_bits), .write_strobe(write_strobe),
        .channel_select(channel_select), .reset_sleep(reset_sleep),
        .pair_ready(pair_ready), .i_segments(i_segments),
        .q_segments(q_segments), .power_down(power_down));
    diidp_host_model diidp_host_model_inst (.clock(clock),
        .pair_ready(pair_ready), .input_code_bits(input_code_bits),
        .write_strobe(write_strobe), .channel_select(channel_select),
        .reset_sleep(reset_sleep));

    initial clock = 1'b0;
    always #(CLK_PERIOD_NS / 2) clock = ~clock;

    function automatic diidp_seg_t seg_of(input logic [CODE_W-1:0] c);
        diidp_seg_t s;
        for (int k = 0; k < SEG_N; k++) begin
            s.upper[k] = (c[UPPER_MSB:UPPER_LSB] > k);
            s.middle[k] = (c[MID_MSB:MID_LSB] > k);
        end
        s.low = c[LOW_MSB:0];
        return s;
    endfunction

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("ERROR at %0t ns: seen %08h expected %08h",
                     $time, seen, exp);
        end
    endtask

    task automatic give_verdict;
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    always @(posedge clock) begin
        cycles++;
        if (cycles == 5000) begin
            err_total++;
            give_verdict;
        end
    end

    task automatic test_reset;
        check(i_segments, 32'h0);
        check(q_segments, 32'h0);
        check(power_down, 1'b0);
        check(pair_ready, 1'b1);
        $display("test_reset done");
    endtask

    // a steady code per channel must come out on both converters together
    task automatic test_tone(input logic [CODE_W-1:0] ci,
                             input logic [CODE_W-1:0] cq);
        logic ok;
        repeat (30) begin
            diidp_host_model_inst.send_pair(ci, cq, ok);
            check(ok, 1'b1);
        end
        repeat (6) begin
            @(posedge clock);
            #1;
            check(i_segments, seg_of(ci));
            check(q_segments, seg_of(cq));
        end
        $display("test_tone %03h %03h done", ci, cq);
    endtask

    task automatic test_short_reset(input logic [CODE_W-1:0] ci);
        diidp_host_model_inst.hold_sleep(3);
        @(posedge clock);
        #1;
        check(power_down, 1'b0);
        check(i_segments, seg_of(ci));
        $display("test_short_reset done");
    endtask

    task automatic test_sleep;
        diidp_host_model_inst.hold_sleep(6);
        check(power_down, 1'b1);
        check(pair_ready, 1'b0);
        check(i_segments, 32'h0);
        check(q_segments, 32'h0);
        repeat (2) @(posedge clock);
        #1;
        check(power_down, 1'b0);
        check(pair_ready, 1'b1);
        $display("test_sleep done");
    endtask

    // a lone Q is dropped and a second I replaces the first; any stray
    // pair would reach the outputs while the buffer keeps flowing
    task automatic test_pairing(input logic [CODE_W-1:0] ci,
                                input logic [CODE_W-1:0] cq);
        logic ok;
        diidp_host_model_inst.put_word(~cq, 1'b0);
        diidp_host_model_inst.put_word(~ci, 1'b1);
        diidp_host_model_inst.put_word(ci, 1'b1);
        diidp_host_model_inst.put_word(cq, 1'b0);
        fork
            repeat (16) begin
                diidp_host_model_inst.send_pair(ci, cq, ok);
                check(ok, 1'b1);
            end
            repeat (70) begin
                @(posedge clock);
                #1;
                check(i_segments, seg_of(ci));
                check(q_segments, seg_of(cq));
            end
        join
        $display("test_pairing done");
    endtask

    initial begin
        rstn = 1'b0;
        repeat (5) @(posedge clock);
        #1;
        rstn = 1'b1;
        test_reset;
        test_tone(10'h3FF, 10'h000);
        test_tone(10'h000, 10'h3FF);
        test_tone(10'h2A5, 10'h15A);
        test_short_reset(10'h2A5);
        test_sleep;
        test_tone(10'h15A, 10'h2A5);
        test_pairing(10'h15A, 10'h2A5);
        give_verdict;
    end
endmodule
`default_nettype wire
